// ===== src/ncpi_defs.svh
// Timing counts and reset values for the NAND channel pin interface
`ifndef NCPI_DEFS_SVH
`define NCPI_DEFS_SVH
`define NCPI_CLK_PERIOD_NS   10
`define NCPI_SETUP_NS        20
`define NCPI_SETUP_CYC       ((`NCPI_SETUP_NS + `NCPI_CLK_PERIOD_NS - 1) / `NCPI_CLK_PERIOD_NS)
`define NCPI_STROBE_NS       20
`define NCPI_STROBE_CYC      ((`NCPI_STROBE_NS + `NCPI_CLK_PERIOD_NS - 1) / `NCPI_CLK_PERIOD_NS)
`define NCPI_HOLD_NS         10
`define NCPI_HOLD_CYC        ((`NCPI_HOLD_NS + `NCPI_CLK_PERIOD_NS - 1) / `NCPI_CLK_PERIOD_NS)
`define NCPI_READ_ACCESS_NS  30
`define NCPI_READ_ACCESS_CYC ((`NCPI_READ_ACCESS_NS + `NCPI_CLK_PERIOD_NS - 1) / `NCPI_CLK_PERIOD_NS)
`define NCPI_BANK_DESEL      4'hf
`endif

// ===== src/ncpi_pkg.sv
// Types shared by the NAND channel pin interface
package ncpi_pkg;
  typedef enum logic [1:0] {
    NCPI_OP_CMD   = 2'h0,
    NCPI_OP_ADDR  = 2'h1,
    NCPI_OP_WDATA = 2'h2,
    NCPI_OP_RDATA = 2'h3
  } ncpi_op_t;

  typedef struct packed {
    ncpi_op_t   op;
    logic [1:0] bank;
    logic [7:0] data;
  } ncpi_req_t;
endpackage

// ===== src/ncpi_channel.sv
// NAND channel pin sequencer: one eight-bit channel, four banks
`timescale 1ns/10ps
`include "ncpi_defs.svh"

module ncpi_channel
  import ncpi_pkg::*;
#(
  parameter int SETUP_CYC  = `NCPI_SETUP_CYC,
  parameter int STROBE_CYC = `NCPI_STROBE_CYC,
  parameter int HOLD_CYC   = `NCPI_HOLD_CYC,
  parameter int READ_CYC   = `NCPI_READ_ACCESS_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Request stream
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire ncpi_req_t  req,
  // Read data stream
  output logic            rd_valid,
  input  wire logic       rd_ready,
  output logic [7:0]      rd_data,
  // Flash pins
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic            cmd_latch,
  output logic            addr_latch,
  output logic [3:0]      bank_select_n,
  input  wire logic [7:0] channel_data_in,
  output logic [7:0]      channel_data_out,
  output logic            channel_data_oe
);

  localparam int CW = 8;

  // The eight-bit down-counter holds the count less one; counts outside 1..255 are refused
  if (SETUP_CYC < 1 || STROBE_CYC < 1 || HOLD_CYC < 1 || READ_CYC < 1 ||
      SETUP_CYC > 255 || STROBE_CYC > 255 || HOLD_CYC > 255 || READ_CYC > 255) begin : bad_timing
    $error("ncpi_channel: timing counts must lie in 1..255");
  end

  typedef enum logic [3:0] {
    NCPI_IDLE   = 4'h1,
    NCPI_SETUP  = 4'h2,
    NCPI_STROBE = 4'h4,
    NCPI_HOLD   = 4'h8
  } ncpi_state_t;

  ncpi_state_t state;
  ncpi_req_t   cur;
  logic [CW-1:0] count;
  // Two-entry read buffer
  logic [7:0]  buf_mem [2];
  logic        wr_ptr;
  logic        rd_ptr;
  logic [1:0]  fill;

  // Active-low select for one bank only
  function automatic logic [3:0] bank_decode(input logic [1:0] b);
    bank_decode = ~(4'h1 << b);
  endfunction

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n - 1);
  endfunction

  logic is_read;
  logic buf_full;
  logic push;
  logic pop;
  assign is_read  = (cur.op == NCPI_OP_RDATA);
  assign buf_full = (fill == 2'h2);
  // Reads wait for a free buffer slot so a stalled receiver loses nothing
  assign req_ready = (state == NCPI_IDLE) && !(req.op == NCPI_OP_RDATA && buf_full);
  assign push = (state == NCPI_STROBE) && is_read && (count == '0);
  assign pop  = rd_valid && rd_ready;

  // Strobe sequencer: setup, strobe, hold
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= NCPI_IDLE;
      cur   <= '0;
      count <= '0;
    end else begin
      case (state)
        NCPI_IDLE: begin
          if (req_valid && req_ready) begin
            cur   <= req;
            count <= cyc(SETUP_CYC);
            state <= NCPI_SETUP;
          end
        end
        NCPI_SETUP: begin
          if (count == '0) begin
            count <= cyc(is_read ? READ_CYC : STROBE_CYC);
            state <= NCPI_STROBE;
          end else begin
            count <= count - 1'b1;
          end
        end
        NCPI_STROBE: begin
          if (count == '0) begin
            count <= cyc(HOLD_CYC);
            state <= NCPI_HOLD;
          end else begin
            count <= count - 1'b1;
          end
        end
        NCPI_HOLD: begin
          if (count == '0) begin
            state <= NCPI_IDLE;  // Bank deselects; a busy flash keeps working
          end else begin
            count <= count - 1'b1;
          end
        end
        default: state <= NCPI_IDLE;
      endcase
    end
  end

  // Pin drivers, all from flip-flops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      write_strobe_n   <= 1'b1;
      read_strobe_n    <= 1'b1;
      cmd_latch        <= 1'b0;
      addr_latch       <= 1'b0;
      bank_select_n    <= `NCPI_BANK_DESEL;
      channel_data_out <= 8'h00;
      channel_data_oe  <= 1'b0;
    end else if (state == NCPI_IDLE && req_valid && req_ready) begin
      bank_select_n    <= bank_decode(req.bank);
      cmd_latch        <= (req.op == NCPI_OP_CMD);
      addr_latch       <= (req.op == NCPI_OP_ADDR);
      channel_data_out <= req.data;
      channel_data_oe  <= (req.op != NCPI_OP_RDATA);
    end else if (state == NCPI_SETUP && count == '0) begin
      write_strobe_n <= is_read;
      read_strobe_n  <= !is_read;
    end else if (state == NCPI_STROBE && count == '0) begin
      write_strobe_n <= 1'b1;  // Rising edge latches the held byte
      read_strobe_n  <= 1'b1;
    end else if (state == NCPI_HOLD && count == '0) begin
      bank_select_n   <= `NCPI_BANK_DESEL;
      cmd_latch       <= 1'b0;
      addr_latch      <= 1'b0;
      channel_data_oe <= 1'b0;
    end
  end

  // Read buffer: sample at end of read strobe, after access delay
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'h0;
    end else begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end

  // Buffer storage has no reset; the fill count says which slots hold data
  always_ff @(posedge ref_clk) begin
    if (push)
      buf_mem[wr_ptr] <= channel_data_in;
  end

  assign rd_valid = (fill != 2'h0);
  assign rd_data  = buf_mem[rd_ptr];

  // Checks
  sel_one_hot_a: assert property (@(posedge ref_clk) disable iff (reset)
    $onehot0(~bank_select_n))
    else $error("more than one bank selected");
  latch_excl_a: assert property (@(posedge ref_clk) disable iff (reset)
    !(cmd_latch && addr_latch))
    else $error("command and address latch both high");
  bus_free_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    !read_strobe_n |-> !channel_data_oe)
    else $error("bus driven during read strobe");
  data_stable_a: assert property (@(posedge ref_clk) disable iff (reset)
    !write_strobe_n ##1 write_strobe_n |-> $stable(channel_data_out) && channel_data_oe)
    else $error("byte moved at write strobe rise");
  wstrobe_sel_a: assert property (@(posedge ref_clk) disable iff (reset)
    !write_strobe_n |-> bank_select_n != `NCPI_BANK_DESEL)
    else $error("write strobe without bank");
  addr_cycle_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(write_strobe_n) && cur.op == NCPI_OP_ADDR |-> addr_latch && !cmd_latch)
    else $error("address cycle without address latch");
  cmd_cycle_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(write_strobe_n) && cur.op == NCPI_OP_CMD |-> cmd_latch && !addr_latch)
    else $error("command cycle without command latch");
  read_push_a: assert property (@(posedge ref_clk) disable iff (reset)
    push |=> $rose(read_strobe_n) && fill != 2'h0)
    else $error("read byte not captured at strobe end");
  reset_idle_a: assert property (@(posedge ref_clk)
    reset |-> bank_select_n == `NCPI_BANK_DESEL && channel_data_oe == 1'b0)
    else $error("pins not idle in reset");
  no_lost_a: assert property (@(posedge ref_clk) disable iff (reset)
    buf_full |-> !push)
    else $error("read buffer overflow");
  strobe_excl_a: assert property (@(posedge ref_clk) disable iff (reset)
    !(!write_strobe_n && !read_strobe_n))
    else $error("read and write strobe both low");

  cmd_c:   cover property (@(posedge ref_clk) $rose(write_strobe_n) && cmd_latch);
  addr_c:  cover property (@(posedge ref_clk) $rose(write_strobe_n) && addr_latch);
  read_c:  cover property (@(posedge ref_clk) push);
  stall_c: cover property (@(posedge ref_clk) buf_full && !rd_ready);

endmodule // ncpi_channel

// ===== verif/ncpi_flash_model.sv
// Behavioural flash devices sitting on one channel
`timescale 1ns/10ps
module ncpi_flash_model (
  // Pins from the sequencer
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic [3:0] bank_select_n,
  input  wire logic [7:0] bus_in,
  // Drive and capture log
  output logic [7:0]      flash_out,
  output logic [1:0]      log_kind,
  output logic [3:0]      log_bank,
  output logic [7:0]      log_byte,
  output int              log_cnt
);
  logic [7:0] col = 8'h00;
  initial log_cnt = 0;
  // Capture on strobe rise; a later deselect cancels nothing
  always @(posedge write_strobe_n) if (bank_select_n != 4'hf) begin
    log_kind = {cmd_latch, addr_latch};
    log_bank = bank_select_n;
    log_byte = bus_in;
    log_cnt++;
  end
  // Column counter steps on each falling read strobe
  always @(negedge read_strobe_n) col = col + 8'h01;
  // Released bus shows the inverse, never a stale byte
  assign flash_out = (!read_strobe_n && bank_select_n != 4'hf) ? col ^ 8'h5a : ~(col ^ 8'h5a);
endmodule // ncpi_flash_model

// ===== verif/testbench.sv
// Self-checking bench for the NAND channel pin sequencer
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((e) !== (a)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module testbench;
  import ncpi_pkg::*;
  logic       ref_clk, reset, req_valid, req_ready, rd_valid, rd_ready;
  logic       write_strobe_n, read_strobe_n, cmd_latch, addr_latch, channel_data_oe;
  ncpi_req_t  req;
  logic [7:0] rd_data, channel_data_out, channel_data_in, flash_out, log_byte, e;
  logic [3:0] bank_select_n, log_bank;
  logic [1:0] log_kind;
  logic [7:0] exp_q[$];
  int         log_cnt, bad_count = 0, total_checks = 0, col = 0, exp_cnt = 0;
  // Wire level from whoever drives it
  assign channel_data_in = channel_data_oe ? channel_data_out : flash_out;
  ncpi_channel dut (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch), .bank_select_n(bank_select_n),
    .channel_data_in(channel_data_in), .channel_data_out(channel_data_out),
    .channel_data_oe(channel_data_oe));
  ncpi_flash_model flash (.write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch), .bank_select_n(bank_select_n),
    .bus_in(channel_data_in), .flash_out(flash_out), .log_kind(log_kind),
    .log_bank(log_bank), .log_byte(log_byte), .log_cnt(log_cnt));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait for idle request side or for deselected pins
  task automatic wait_for(input bit pins);
    int n;
    n = 0;
    while ((pins ? bank_select_n !== 4'hf : req_ready !== 1'b1) && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 100) begin
      bad_count++;
      complete_run();
    end
  endtask
  // One access; pins checked while it stands, result after it ends
  task automatic send(input ncpi_op_t op, input logic [1:0] bank, input logic [7:0] data);
    req = '{op, bank, data};
    wait_for(1'b0);
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    @(negedge ref_clk);
    `CHK("bank", ~(4'h1 << bank), bank_select_n)
    `CHK("latch", {op == NCPI_OP_CMD, op == NCPI_OP_ADDR}, {cmd_latch, addr_latch})
    `CHK("drive", op != NCPI_OP_RDATA, channel_data_oe)
    wait_for(1'b1);
    if (op == NCPI_OP_RDATA) begin
      col++;
      exp_q.push_back(8'(col) ^ 8'h5a);
    end else begin
      exp_cnt++;
      `CHK("log", {op == NCPI_OP_CMD, op == NCPI_OP_ADDR, ~(4'h1 << bank), data},
        {log_kind, log_bank, log_byte})
      `CHK("count", exp_cnt, log_cnt)
    end
  endtask
  // Consumer drains the buffer in order
  task automatic drain;
    int n;
    n = 0;
    rd_ready = 1'b1;
    while (exp_q.size() > 0 && n < 100) begin
      if (rd_valid === 1'b1) begin
        e = exp_q.pop_front();
        `CHK("rd_data", e, rd_data)
      end
      @(negedge ref_clk);
      n++;
    end
    rd_ready = 1'b0;
    if (exp_q.size() > 0) begin
      bad_count++;
      complete_run();
    end
    `CHK("rd_valid", 1'b0, rd_valid)
  endtask
  initial begin
    reset = 1'b0;
    req_valid = 1'b0;
    rd_ready = 1'b0;
    req = '0;
    void'($urandom(32'h888273f1));
    // Raise reset after time zero so its edge is never missed
    #1 reset = 1'b1;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    // Command, address and write bytes to random banks, back to back
    for (int i = 0; i < 12; i++) send(ncpi_op_t'(2'(i % 3)), 2'($urandom), 8'($urandom));
    $display("test writes done");
    // Two reads per bank while the consumer stalls; a third is refused
    for (int b = 0; b < 4; b++) begin
      send(NCPI_OP_RDATA, 2'(b), 8'($urandom));
      send(NCPI_OP_RDATA, 2'(b), 8'($urandom));
      req.op = NCPI_OP_RDATA;
      `CHK("refuse", 1'b0, req_ready)
      req_valid = 1'b1;
      @(negedge ref_clk);
      req_valid = 1'b0;
      `CHK("held off", 4'hf, bank_select_n)
      drain();
    end
    $display("test reads done");
    // Reset lands in mid-access, then traffic resumes
    req_valid = 1'b1;
    req = '{NCPI_OP_CMD, 2'h2, 8'($urandom)};
    @(negedge ref_clk);
    req_valid = 1'b0;
    @(negedge ref_clk);
    reset = 1'b1;
    @(negedge ref_clk);
    `CHK("reset", 11'h679, {write_strobe_n, read_strobe_n, cmd_latch, addr_latch,
      bank_select_n, channel_data_oe, rd_valid, req_ready})
    reset = 1'b0;
    send(NCPI_OP_WDATA, 2'h3, 8'($urandom));
    $display("test reset done");
    complete_run();
  end
endmodule // testbench
